/* File: link_sync_pkg.sv */
// constants and types shared by the link request and marker selection block
package link_sync_pkg;

   // ---------------------------------------------------------------
   // register bus
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   localparam logic [7:0] OFF_CTRL   = 8'h00; // control, read/write
   localparam logic [7:0] OFF_STATUS = 8'h04; // live state, read only
   localparam logic [7:0] OFF_MARKS  = 8'h08; // sample mark count, read only

   // ---------------------------------------------------------------
   // control field positions and reset value
   // ---------------------------------------------------------------
   localparam int CTRL_W           = 4;
   localparam int CTRL_SYNC_SEL    = 0; // 0 = single-ended pin, 1 = marker pair
   localparam int CTRL_MARK_EN     = 1; // sample marking on
   localparam int CTRL_RECV_EN     = 2; // marker_receiver_enable
   localparam int CTRL_MODE_64B66B = 3; // 1 = 64b/66b, 0 = 8b/10b

   localparam logic [3:0] CTRL_RESET = 4'h0;

   // ---------------------------------------------------------------
   // status field positions
   // ---------------------------------------------------------------
   localparam int STAT_STATE_LSB = 0; // four one-hot state bits
   localparam int STAT_REQ       = 4; // selected request asserted
   localparam int STAT_MARK      = 5; // marker level seen

   // ---------------------------------------------------------------
   // counts
   // ---------------------------------------------------------------
   localparam int ILAS_CYCLES  = 16; // cycles of the alignment sequence
   localparam int ILAS_CNT_W   = 8;
   localparam int MARK_CNT_W   = 16;

   // ---------------------------------------------------------------
   // link bring-up states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_CGS  = 4'b0010,
      ST_ILAS = 4'b0100,
      ST_DATA = 4'b1000
   } link_state_type;

endpackage

/* File: link_request_select.sv */
// selects the link request source and decodes the differential marker pair
`timescale 1ns/1ns

module link_request_select (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic sync_sel,
   input  wire logic recv_en,
   input  wire logic single_ended_link_request_n,
   input  wire logic sample_marker_pair_p,
   input  wire logic sample_marker_pair_n,
   output logic      req_asserted,
   output logic      marker_high
);

   typedef struct packed {
      logic req;
      logic mark;
   } sel_state_type;

   sel_state_type st_ff;
   sel_state_type nxt_st;
   logic          pair_high;
   logic          pair_low;

   // ---------------------------------------------------------------
   // pair decode and source choice
   // ---------------------------------------------------------------
   // a disabled receiver reads as neither high nor low
   always_comb begin
      pair_high = recv_en & sample_marker_pair_p & ~sample_marker_pair_n;
      pair_low  = recv_en & ~sample_marker_pair_p & sample_marker_pair_n;
      nxt_st      = st_ff;
      nxt_st.mark = pair_high;
      if (sync_sel) begin
         nxt_st.req = pair_low;
      end else begin
         nxt_st.req = ~single_ended_link_request_n;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign req_asserted = st_ff.req;
   assign marker_high  = st_ff.mark;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_disabled_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      !recv_en |=> !marker_high && !($past(sync_sel) && req_asserted))
      else $error("disabled marker receiver produced activity");

   chk_pin_select: assert property (@(posedge clock) disable iff (!rst_n)
      !sync_sel |=> req_asserted == !$past(single_ended_link_request_n))
      else $error("single-ended request not followed");

   chk_pair_low_req: assert property (@(posedge clock) disable iff (!rst_n)
      sync_sel && recv_en && !sample_marker_pair_p && sample_marker_pair_n
      |=> req_asserted)
      else $error("low marker pair did not assert request");

endmodule

/* File: link_sync_top.sv */
// link request handling, link bring-up sequencing and sample marking
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ns

module link_sync_top #(
   parameter int unsigned ILAS_CYCLES = link_sync_pkg::ILAS_CYCLES
) (
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WR_DATA,
   input  wire logic        WR_STB,
   input  wire logic        RD_STB,
   output logic      [31:0] RD_DATA,
   input  wire logic        SINGLE_ENDED_LINK_REQUEST_N,
   input  wire logic        SAMPLE_MARKER_PAIR_P,
   input  wire logic        SAMPLE_MARKER_PAIR_N,
   output logic             CGS_ACTIVE,
   output logic             ILAS_ACTIVE,
   output logic             LINK_DATA_ACTIVE,
   output logic             NCO_SYNC_TRIGGER,
   output logic             SAMPLE_MARK
);

   typedef struct packed {
      link_sync_pkg::link_state_type state;
      logic [7:0]                    ilas_cnt;
      logic                          req_prev;
      logic                          mark_prev;
      logic [3:0]                    ctrl;
      logic                          nco_trig;
      logic                          mark_pulse;
      logic [15:0]                   mark_count;
      logic [31:0]                   rd_data;
   } top_state_type;

   top_state_type st_ff;
   top_state_type nxt_st;
   logic          req_q;
   logic          mark_q;
   logic          mode_64b;
   logic          mark_en;
   logic [7:0]    ilas_last;

   // ---------------------------------------------------------------
   // register read decode
   // ---------------------------------------------------------------
   // unmapped addresses read as zero
   function automatic logic [31:0] read_word(input logic [7:0]    addr,
                                             input top_state_type s,
                                             input logic          req,
                                             input logic          mark);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (addr)
         link_sync_pkg::OFF_CTRL: begin
            w[3:0] = s.ctrl;
         end
         link_sync_pkg::OFF_STATUS: begin
            w[3:0]                      = s.state;
            w[link_sync_pkg::STAT_REQ]  = req;
            w[link_sync_pkg::STAT_MARK] = mark;
         end
         link_sync_pkg::OFF_MARKS: begin
            w[15:0] = s.mark_count;
         end
         default: begin
            w = 32'h0000_0000;
         end
      endcase
      return w;
   endfunction

   // ---------------------------------------------------------------
   // input selection
   // ---------------------------------------------------------------
   link_request_select u_select (
      .clock                       (CLOCK),
      .rst_n                       (RST_N),
      .sync_sel                    (st_ff.ctrl[link_sync_pkg::CTRL_SYNC_SEL]),
      .recv_en                     (st_ff.ctrl[link_sync_pkg::CTRL_RECV_EN]),
      .single_ended_link_request_n (SINGLE_ENDED_LINK_REQUEST_N),
      .sample_marker_pair_p        (SAMPLE_MARKER_PAIR_P),
      .sample_marker_pair_n        (SAMPLE_MARKER_PAIR_N),
      .req_asserted                (req_q),
      .marker_high                 (mark_q)
   );

   assign mode_64b  = st_ff.ctrl[link_sync_pkg::CTRL_MODE_64B66B];
   assign mark_en   = st_ff.ctrl[link_sync_pkg::CTRL_MARK_EN];
   assign ilas_last = 8'(ILAS_CYCLES - 1);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st           = st_ff;
      nxt_st.req_prev  = req_q;
      nxt_st.mark_prev = mark_q;
      nxt_st.rd_data   = 32'h0000_0000;

      // register port: write takes effect next cycle, read answers next cycle
      if (WR_STB && ADDR == link_sync_pkg::OFF_CTRL) begin
         nxt_st.ctrl = WR_DATA[3:0];
      end
      if (RD_STB) begin
         nxt_st.rd_data = read_word(ADDR, st_ff, req_q, mark_q);
      end

      // oscillator sync trigger on each new request, in every mode
      nxt_st.nco_trig = req_q & ~st_ff.req_prev;

      // sample mark on the rising marker level, independent of request use
      nxt_st.mark_pulse = mark_en & mark_q & ~st_ff.mark_prev;
      if (nxt_st.mark_pulse) begin
         nxt_st.mark_count = st_ff.mark_count + 16'h0001;
      end

      // link bring-up only in 8b/10b modes
      if (mode_64b) begin
         nxt_st.state    = link_sync_pkg::ST_IDLE;
         nxt_st.ilas_cnt = 8'h00;
      end else begin
         case (st_ff.state)
            link_sync_pkg::ST_IDLE: begin
               if (req_q) begin
                  nxt_st.state = link_sync_pkg::ST_CGS;
               end
            end
            link_sync_pkg::ST_CGS: begin
               if (!req_q) begin
                  nxt_st.state    = link_sync_pkg::ST_ILAS;
                  nxt_st.ilas_cnt = 8'h00;
               end
            end
            link_sync_pkg::ST_ILAS: begin
               if (req_q) begin
                  nxt_st.state = link_sync_pkg::ST_CGS;
               end else if (st_ff.ilas_cnt == ilas_last) begin
                  nxt_st.state = link_sync_pkg::ST_DATA;
               end else begin
                  nxt_st.ilas_cnt = st_ff.ilas_cnt + 8'h01;
               end
            end
            link_sync_pkg::ST_DATA: begin
               if (req_q) begin
                  nxt_st.state = link_sync_pkg::ST_CGS;
               end
            end
            default: begin
               nxt_st.state = link_sync_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         st_ff       <= '0;
         st_ff.state <= link_sync_pkg::ST_IDLE;
         st_ff.ctrl  <= link_sync_pkg::CTRL_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from the state register
   assign RD_DATA          = st_ff.rd_data;
   // one-hot state bits drive the phase outputs with no gate in between
   assign CGS_ACTIVE       = st_ff.state[1];
   assign ILAS_ACTIVE      = st_ff.state[2];
   assign LINK_DATA_ACTIVE = st_ff.state[3];
   assign NCO_SYNC_TRIGGER = st_ff.nco_trig;
   assign SAMPLE_MARK      = st_ff.mark_pulse;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);

   sequence idle_then_request;
      !mode_64b && st_ff.state == link_sync_pkg::ST_IDLE ##0 req_q;
   endsequence

   sequence cgs_then_release;
      !mode_64b && CGS_ACTIVE ##0 !req_q;
   endsequence

   sequence marker_rise;
      mark_en && mark_q && !$past(mark_q);
   endsequence

   chk_cgs_on_request: assert property (idle_then_request |=> CGS_ACTIVE)
      else $error("request did not start code group sync");

   chk_ilas_after_release: assert property (cgs_then_release |=> ILAS_ACTIVE)
      else $error("release did not start alignment");

   chk_ilas_needs_release: assert property ($rose(ILAS_ACTIVE) |-> !$past(req_q))
      else $error("alignment began while request held");

   chk_ilas_to_data: assert property (
      ILAS_ACTIVE && !req_q && !mode_64b && st_ff.ilas_cnt == ilas_last
      |=> LINK_DATA_ACTIVE)
      else $error("alignment length wrong");

   chk_64b_no_bringup: assert property (mode_64b |=> !CGS_ACTIVE && !ILAS_ACTIVE)
      else $error("bring-up ran in 64b/66b mode");

   chk_nco_trigger: assert property ($rose(req_q) |=> NCO_SYNC_TRIGGER ##1 !NCO_SYNC_TRIGGER)
      else $error("oscillator trigger not a single pulse");

   chk_mark_pulse: assert property (marker_rise |=> SAMPLE_MARK)
      else $error("marker edge gave no sample mark");

   chk_mark_gated: assert property (!mark_en |=> !SAMPLE_MARK)
      else $error("sample mark while marking disabled");

endmodule

/* File: link_rx_model.sv */
// far-end link receiver model driving the request pin and the marker pair
`timescale 1ns/1ns

module link_rx_model (
   input  wire logic clock,
   input  wire logic use_pair,
   input  wire logic want_sync,
   input  wire logic mark_hi,
   output logic      req_pin_n,
   output logic      pair_p,
   output logic      pair_n
);
   logic level;

   // pair level: active-low request when it carries the sync, else the marker
   always_comb begin
      level = use_pair ? ~want_sync : mark_hi;
   end

   // lines change just after the edge; the unused pin is grounded
   always @(posedge clock) begin
      req_pin_n <= use_pair ? 1'b0 : ~want_sync;
      pair_p    <= level;
      pair_n    <= ~level;
   end
endmodule

/* File: link_sync_top_tb.sv */
// self-checking bench for the link request and marker selection block
`timescale 1ns/1ns

module link_sync_top_tb;
   localparam int ILAS_N = 4;
   logic        clock, rst_n, wr_stb, rd_stb, use_pair, want_sync, mark_hi;
   logic [7:0]  addr;
   logic [31:0] wr_data, rd_data;
   logic        pin_n, pair_p, pair_n, cgs, ilas, data_on, nco, mark;
   int          mismatches, compares, nco_cnt, mark_cnt, ilas_len, n0;

   link_sync_top #(.ILAS_CYCLES(ILAS_N)) i_link_sync_top (
      .CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb),
      .RD_STB(rd_stb), .RD_DATA(rd_data), .SINGLE_ENDED_LINK_REQUEST_N(pin_n),
      .SAMPLE_MARKER_PAIR_P(pair_p), .SAMPLE_MARKER_PAIR_N(pair_n), .CGS_ACTIVE(cgs),
      .ILAS_ACTIVE(ilas), .LINK_DATA_ACTIVE(data_on), .NCO_SYNC_TRIGGER(nco),
      .SAMPLE_MARK(mark));

   link_rx_model i_link_rx_model (
      .clock(clock), .use_pair(use_pair), .want_sync(want_sync), .mark_hi(mark_hi),
      .req_pin_n(pin_n), .pair_p(pair_p), .pair_n(pair_n));

   // --------------------------------------------------------
   // clock and pulse counters
   // --------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   always @(posedge clock) begin
      if (nco === 1'b1) nco_cnt++;
      if (mark === 1'b1) mark_cnt++;
      if (ilas === 1'b1) ilas_len++;
   end

   // --------------------------------------------------------
   // shared tasks
   // --------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic settle();
      repeat (5) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr    <= a;
      wr_data <= d;
      wr_stb  <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge clock);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      @(negedge clock);
      check(what, rd_data, exp);
   endtask

   task automatic link(input logic [2:0] exp);
      check("link phase", {29'h0, cgs, ilas, data_on}, {29'h0, exp});
   endtask

   task automatic set_req(input logic v);
      @(posedge clock);
      want_sync <= v;
      settle();
   endtask

   task automatic mark_pulse();
      @(posedge clock);
      mark_hi <= 1'b1;
      settle();
      @(posedge clock);
      mark_hi <= 1'b0;
      settle();
   endtask

   // --------------------------------------------------------
   // scenarios
   // --------------------------------------------------------
   task automatic t_reset();
      rd_chk(link_sync_pkg::OFF_CTRL, 32'h0, "ctrl reset");
      rd_chk(link_sync_pkg::OFF_STATUS, 32'h1, "status reset");
      rd_chk(link_sync_pkg::OFF_MARKS, 32'h0, "marks reset");
      rd_chk(8'h0c, 32'h0, "unmapped read");
      wr(link_sync_pkg::OFF_STATUS, 32'hf);
      rd_chk(link_sync_pkg::OFF_CTRL, 32'h0, "ctrl after stray write");
   endtask

   task automatic t_pin_bringup();
      n0 = nco_cnt;
      set_req(1'b1);
      link(3'b100);
      check("trigger pulses", nco_cnt - n0, 1);
      settle();
      link(3'b100);
      ilas_len = 0;
      set_req(1'b0);
      link(3'b010);
      settle();
      link(3'b001);
      check("alignment length", ilas_len, ILAS_N);
      rd_chk(link_sync_pkg::OFF_STATUS, 32'h8, "status data");
      set_req(1'b1);
      link(3'b100);
      set_req(1'b0);
      settle();
   endtask

   task automatic t_wide_mode();
      wr(link_sync_pkg::OFF_CTRL, 32'h8);
      n0 = nco_cnt;
      set_req(1'b1);
      link(3'b000);
      check("trigger pulses", nco_cnt - n0, 1);
      rd_chk(link_sync_pkg::OFF_STATUS, 32'h11, "status wide mode");
      set_req(1'b0);
      link(3'b000);
   endtask

   task automatic t_pair_request();
      // select the pair before the far end grounds the pin, so no stray request
      wr(link_sync_pkg::OFF_CTRL, 32'h1);
      use_pair <= 1'b1;
      set_req(1'b1);
      link(3'b000);
      rd_chk(link_sync_pkg::OFF_STATUS, 32'h1, "status receiver off");
      wr(link_sync_pkg::OFF_CTRL, 32'h5);
      settle();
      link(3'b100);
      set_req(1'b0);
      link(3'b010);
      settle();
      link(3'b001);
   endtask

   task automatic t_marking();
      use_pair <= 1'b0;
      wr(link_sync_pkg::OFF_CTRL, 32'h2);
      n0 = mark_cnt;
      mark_pulse();
      check("marks receiver off", mark_cnt - n0, 0);
      wr(link_sync_pkg::OFF_CTRL, 32'h6);
      mark_pulse();
      check("marks enabled", mark_cnt - n0, 1);
      wr(link_sync_pkg::OFF_CTRL, 32'h4);
      mark_pulse();
      check("marks disabled", mark_cnt - n0, 1);
      use_pair  <= 1'b1;
      want_sync <= 1'b1;
      wr(link_sync_pkg::OFF_CTRL, 32'h7);
      settle();
      link(3'b100);
      set_req(1'b0);
      link(3'b010);
      check("marks shared pair", mark_cnt - n0, 2);
      rd_chk(link_sync_pkg::OFF_MARKS, 32'h2, "mark count");
      rd_chk(link_sync_pkg::OFF_STATUS, 32'h28, "status shared pair");
   endtask

   // --------------------------------------------------------
   // verdict, watchdog and main sequence
   // --------------------------------------------------------
   task automatic print_verdict();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #100000;
      mismatches++;
      print_verdict();
   end

   initial begin
      rst_n     = 1'b0;
      addr      = 8'h00;
      wr_data   = 32'h0;
      wr_stb    = 1'b0;
      rd_stb    = 1'b0;
      use_pair  = 1'b0;
      want_sync = 1'b0;
      mark_hi   = 1'b0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_pin_bringup();
      t_wide_mode();
      t_pair_request();
      t_marking();
      print_verdict();
   end
endmodule
